// [inc/apms_defs.vh]
// constants for the converter power-mode sequencer
`ifndef APMS_DEFS_VH
`define APMS_DEFS_VH

`define APMS_SEL_DEEP 2'h0
`define APMS_SEL_QUICK 2'h1
`define APMS_SEL_LOW 2'h2
`define APMS_SEL_NORMAL 2'h3
`define APMS_SEL_HI_BIT 1
`define APMS_SEL_LO_BIT 0
`define APMS_CTRL_BITS 8
`define APMS_LAST_CTRL_BIT 4'h7
`define APMS_RESULT_BITS 12
`define APMS_CLK_MHZ 50
`define APMS_WAKE_NS 2000
`define APMS_WAKE_CYCLES ((`APMS_WAKE_NS * `APMS_CLK_MHZ + 999) / 1000)

`endif

// [src/apms_sync_edge.v]
// two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module apms_sync_edge #(
   parameter RESET_VALUE = 1'b0
) (
   // clock and reset
   input wire core_clk,
   input wire reset_n,
   // asynchronous level in
   input wire async_in,
   // synchronised level and edges
   output reg level,
   output wire rise,
   output wire fall
);
   reg stage1;
   reg prev;

   always @(posedge core_clk) begin
      if (!reset_n) begin
         stage1 <= RESET_VALUE;
         level <= RESET_VALUE;
         prev <= RESET_VALUE;
      end else begin
         stage1 <= async_in;
         level <= stage1;
         prev <= level;
      end
   end

   assign rise = level & ~prev;
   assign fall = ~level & prev;
endmodule // apms_sync_edge

// [src/apms_sequencer.v]
// power-mode sequencer of a serial 12-bit converter
`timescale 1ns/1ps
`include "apms_defs.vh"

// Operation
// - power field 00 deep, 01 quick, 10 low power, 11 normal
// - after conversion enter latest programmed state until next control byte
// - low-power state applies only between conversions; conversion runs full power
// - requested low-power mode waits for the running conversion to finish
// - first one on data input is start bit, wakes to full power only from deep sleep
// - power field of each control byte picks state after its conversion
// - shutdown low forces power-down and aborts conversion at once
// - after shutdown release, ready to convert after the input synchroniser plus the 2 us wake count
// - deep sleep or shutdown exit go to full power, ready after 2 us; reset enters full-power idle directly, without the wake count
// - quick sleep and low power allow immediate conversion start
// - results are binary codes over 4096 steps
// - power field is bits 1 and 0 of the control byte
// - serial interface stays active in every software low-power state
// - power-on reset starts in normal mode with strobe low
module apms_sequencer #(
   parameter RESULT_BITS = `APMS_RESULT_BITS,
   parameter WAKE_CYCLES = `APMS_WAKE_CYCLES
) (
   // clock and reset
   input wire core_clk,
   input wire reset_n,
   // serial link from the host
   input wire serial_clk,
   input wire chip_select_n,
   input wire serial_din,
   input wire hw_shutdown_n,
   // converter core
   input wire comparator_bit,
   // serial answer
   output reg serial_dout,
   output reg serial_dout_oe,
   output reg conversion_strobe,
   output reg conversion_strobe_oe,
   // power and status
   output reg [1:0] power_sel,
   output reg comparator_on,
   output reg comparator_full,
   output reg reference_on,
   output reg converting,
   output reg ready,
   output reg [RESULT_BITS-1:0] result_code,
   output reg result_valid
);
   // one-hot power states
   localparam ST_SHUTDOWN = 6'h01;
   localparam ST_WAKE = 6'h02;
   localparam ST_IDLE_FULL = 6'h04;
   localparam ST_CONVERT = 6'h08;
   localparam ST_SLEEP = 6'h10;
   localparam ST_DEEP = 6'h20;

   wire sclk_rise;
   wire sclk_fall;
   wire cs_level;
   wire din_level;
   wire hw_shutdown_n_level;
   wire hw_shutdown_n_rise;

   apms_sync_edge #(.RESET_VALUE(1'b0)) u_sclk (
      .core_clk(core_clk), .reset_n(reset_n), .async_in(serial_clk),
      .level(), .rise(sclk_rise), .fall(sclk_fall));
   apms_sync_edge #(.RESET_VALUE(1'b1)) u_cs (
      .core_clk(core_clk), .reset_n(reset_n), .async_in(chip_select_n),
      .level(cs_level), .rise(), .fall());
   apms_sync_edge #(.RESET_VALUE(1'b0)) u_din (
      .core_clk(core_clk), .reset_n(reset_n), .async_in(serial_din),
      .level(din_level), .rise(), .fall());
   apms_sync_edge #(.RESET_VALUE(1'b1)) u_hw_shutdown_n (
      .core_clk(core_clk), .reset_n(reset_n), .async_in(hw_shutdown_n),
      .level(hw_shutdown_n_level), .rise(hw_shutdown_n_rise), .fall());

   reg [5:0] state;
   reg [5:0] next_state;
   reg [`APMS_CTRL_BITS-1:0] shift;
   reg [3:0] bit_count;
   reg receiving;
   reg [1:0] pending_sel;
   reg [4:0] conv_count;
   reg strobe_arm;
   reg [15:0] wake_count;
   wire selected = ~cs_level & hw_shutdown_n_level;
   wire byte_done = selected & sclk_rise & receiving & (bit_count == `APMS_LAST_CTRL_BIT);
   wire start_bit = selected & sclk_rise & ~receiving & din_level & ~state[3];
   wire conv_done = state[3] & sclk_rise & (conv_count == RESULT_BITS[4:0] - 5'h01);

   // control byte reception; the serial side stays active in every state but shutdown
   always @(posedge core_clk) begin
      if (!reset_n) begin
         shift <= {`APMS_CTRL_BITS{1'b0}};
         bit_count <= 4'h0;
         receiving <= 1'b0;
         pending_sel <= `APMS_SEL_NORMAL;
      end else if (!hw_shutdown_n_level || cs_level) begin
         receiving <= 1'b0;
         bit_count <= 4'h0;
      end else if (sclk_rise) begin
         if (start_bit) begin
            receiving <= 1'b1;
            bit_count <= 4'h1;
            shift <= {{(`APMS_CTRL_BITS-1){1'b0}}, 1'b1};
         end else if (receiving) begin
            shift <= {shift[`APMS_CTRL_BITS-2:0], din_level};
            bit_count <= bit_count + 4'h1;
            if (bit_count == `APMS_LAST_CTRL_BIT) begin
               receiving <= 1'b0;
               pending_sel <= {shift[`APMS_SEL_LO_BIT], din_level};
            end
         end
      end
   end

   // power state sequencing
   always @* begin
      next_state = state;
      case (state)
         ST_SHUTDOWN: if (hw_shutdown_n_level) next_state = ST_WAKE;
         // a byte that completes before the wake count ends is dropped,
         // so a fast host loses its wake-up frame after deep sleep
         ST_WAKE: if (wake_count == 16'h0000) next_state = ST_IDLE_FULL;
         ST_IDLE_FULL, ST_SLEEP: if (byte_done) next_state = ST_CONVERT;
         ST_DEEP: if (start_bit) next_state = ST_WAKE;
         ST_CONVERT: begin
            if (conv_done) begin
               if (pending_sel == `APMS_SEL_DEEP) next_state = ST_DEEP;
               else if (pending_sel == `APMS_SEL_NORMAL) next_state = ST_IDLE_FULL;
               else next_state = ST_SLEEP;
            end
         end
         default: next_state = ST_SHUTDOWN;
      endcase
      if (!hw_shutdown_n_level) next_state = ST_SHUTDOWN;
   end

   // section enables of the state being entered; sleep keeps the comparator reduced
   reg next_comparator_on;
   reg next_comparator_full;
   reg next_reference_on;
   always @* begin
      next_comparator_on = 1'b1;
      next_comparator_full = 1'b1;
      next_reference_on = 1'b1;
      case (next_state)
         ST_SHUTDOWN, ST_DEEP: begin
            next_comparator_on = 1'b0;
            next_comparator_full = 1'b0;
            next_reference_on = 1'b0;
         end
         ST_SLEEP: next_comparator_full = (pending_sel == `APMS_SEL_NORMAL);
         default: next_comparator_full = 1'b1;
      endcase
   end

   always @(posedge core_clk) begin
      if (!reset_n) begin
         state <= ST_IDLE_FULL;
         wake_count <= 16'h0000;
         conv_count <= 5'h00;
         strobe_arm <= 1'b0;
      end else begin
         state <= next_state;
         if (next_state == ST_WAKE && state != ST_WAKE)
            wake_count <= WAKE_CYCLES[15:0] - 16'h0001;
         else if (wake_count != 16'h0000)
            wake_count <= wake_count - 16'h0001;
         if (state != ST_CONVERT) conv_count <= 5'h00;
         else if (sclk_rise) conv_count <= conv_count + 5'h01;
         if (byte_done) strobe_arm <= 1'b1;
         else if (sclk_rise || !hw_shutdown_n_level) strobe_arm <= 1'b0;
      end
   end

   // converter outputs; strobe rises one clock after the byte and falls after the next bit clock rise
   always @(posedge core_clk) begin
      if (!reset_n) begin
         serial_dout <= 1'b0;
         serial_dout_oe <= 1'b0;
         conversion_strobe <= 1'b0;
         conversion_strobe_oe <= 1'b0;
         power_sel <= `APMS_SEL_NORMAL;
         comparator_on <= 1'b1;
         comparator_full <= 1'b1;
         reference_on <= 1'b1;
         converting <= 1'b0;
         ready <= 1'b0;
         result_code <= {RESULT_BITS{1'b0}};
         result_valid <= 1'b0;
      end else begin
         power_sel <= pending_sel;
         serial_dout_oe <= ~cs_level;
         conversion_strobe_oe <= ~cs_level;
         conversion_strobe <= strobe_arm | (byte_done & ~cs_level);
         converting <= next_state[3];
         ready <= next_state[2] | next_state[4];
         comparator_on <= next_comparator_on;
         comparator_full <= next_comparator_full;
         reference_on <= next_reference_on;
         result_valid <= conv_done & hw_shutdown_n_level;
         if (!hw_shutdown_n_level) begin
            serial_dout <= 1'b0;
         end else if (state[3] && sclk_rise) begin
            serial_dout <= comparator_bit;
            result_code <= {result_code[RESULT_BITS-2:0], comparator_bit};
         end else if (sclk_rise) begin
            // zeros lead and trail the result
            serial_dout <= 1'b0;
         end
      end
   end
endmodule // apms_sequencer

// [testbench/apms_seq_asserts.sv]
// port assertions for the power-mode sequencer
`timescale 1ns/1ps
module apms_seq_asserts #(
   parameter WAKE_CYCLES = 100
) (
   // clock and reset
   input wire core_clk,
   input wire reset_n,
   // watched ports
   input wire hw_shutdown_n,
   input wire [1:0] power_sel,
   input wire comparator_on,
   input wire comparator_full,
   input wire reference_on,
   input wire converting,
   input wire ready,
   input wire result_valid,
   input wire conversion_strobe
);
   // shutdown pin passes a two-flop synchroniser before the wake count
   localparam int WMAX = WAKE_CYCLES + 8;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   a_conv_full_power: assert property (converting |-> comparator_full && reference_on)
      else $error("section below full power while converting");
   a_hw_shutdown_n_abort: assert property ($fell(hw_shutdown_n) |-> ##[1:5] !converting)
      else $error("conversion survives shutdown");
   a_hw_shutdown_n_hold_idle: assert property (!hw_shutdown_n [*5] |-> !converting && !ready)
      else $error("activity while shutdown held");
   a_deep_off: assert property (result_valid && power_sel == 2'h0 |-> ##[0:3] !comparator_on && !reference_on)
      else $error("deep sleep leaves sections on");
   a_sleep_part: assert property (result_valid && (power_sel == 2'h1 || power_sel == 2'h2)
      |-> ##[0:3] comparator_on && !comparator_full && reference_on)
      else $error("sleep state sections wrong");
   a_normal_on: assert property (result_valid && power_sel == 2'h3 |-> ##[0:3] comparator_full)
      else $error("normal state not at full power");
   a_wake_ready: assert property ($rose(hw_shutdown_n) |-> ##[1:WMAX] ready)
      else $error("not ready after shutdown release");
   a_reset_state: assert property ($rose(reset_n) |-> !conversion_strobe && power_sel == 2'h3)
      else $error("wrong state after reset");
endmodule // apms_seq_asserts
bind apms_sequencer apms_seq_asserts #(.WAKE_CYCLES(WAKE_CYCLES)) chk (.core_clk, .reset_n, .hw_shutdown_n,
   .power_sel, .comparator_on, .comparator_full, .reference_on, .converting, .ready, .result_valid,
   .conversion_strobe);

// [testbench/apms_host.sv]
// serial host master model driving the link
`timescale 1ns/1ps
module apms_host (
   // link out
   output reg serial_clk,
   output reg chip_select_n,
   output reg serial_din
);
   integer half;
   reg [1:0] last_sel;
   initial begin
      last_sel = 2'h3;
      serial_clk = 1'b0;
      chip_select_n = 1'b1;
      serial_din = 1'b1;
   end
   // clock stands low outside frames; zeros follow the byte
   task frame(input [7:0] ctrl);
      integer i;
      begin
         // slow clock while the programmed or the new field is quick sleep or low power
         half = ((ctrl[1] ^ ctrl[0]) || (last_sel[1] ^ last_sel[0])) ? 120 : 80;
         #7 chip_select_n = 1'b0;
         for (i = 0; i < 28; i = i + 1) begin
            serial_din = (i < 8) ? ctrl[7 - i] : 1'b0;
            #(half) serial_clk = 1'b1;
            #(half) serial_clk = 1'b0;
         end
         #(half) chip_select_n = 1'b1;
         serial_din = ~serial_din;
         last_sel = ctrl[1:0];
         // select stays high long enough for the synchroniser between frames
         #(4 * half);
      end
   endtask
endmodule // apms_host

// [testbench/apms_sequencer_tb.sv]
// self-checking bench for the power-mode sequencer
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin mismatches++; $display("BAD %s exp %h got %h", n, e, s); end end
module apms_sequencer_tb;
   reg core_clk, reset_n, hw_shutdown_n, comparator_bit, sclk_q;
   wire serial_clk, chip_select_n, serial_din, result_valid;
   wire serial_dout, serial_dout_oe, conversion_strobe, conversion_strobe_oe;
   wire [1:0] power_sel;
   wire [11:0] result_code;
   reg [11:0] exp_code;
   reg [31:0] seed = 32'h16A3A;
   reg [1:0] f;
   integer mismatches = 0, compares = 0, cycles = 0, rcnt = 0, nres = 0, i;
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   apms_host host (.serial_clk, .chip_select_n, .serial_din);
   apms_sequencer #(.WAKE_CYCLES(4)) uut (.core_clk, .reset_n, .serial_clk, .chip_select_n, .serial_din,
      .hw_shutdown_n, .comparator_bit, .serial_dout, .serial_dout_oe, .conversion_strobe,
      .conversion_strobe_oe, .power_sel, .comparator_on(), .comparator_full(), .reference_on(),
      .converting(), .ready(), .result_code, .result_valid);
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task wrap_up;
      begin
         $display("compares %0d mismatches %0d", compares, mismatches);
         if (mismatches == 0 && compares > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         mismatches = mismatches + 1;
         wrap_up;
      end
   end
   // model: decisions taken at rises 9 to 20 form the code
   always @(negedge core_clk) begin
      sclk_q <= serial_clk;
      if (serial_clk && !sclk_q && !chip_select_n) begin
         rcnt <= rcnt + 1;
         if (rcnt >= 8 && rcnt < 20) exp_code <= {exp_code[10:0], comparator_bit};
      end
      if (!serial_clk && sclk_q) begin
         seed = xs(seed);
         comparator_bit <= seed[0];
         // at each bit clock fall: result bit after rises 9 to 20, strobe after the byte
         if (!chip_select_n && hw_shutdown_n) begin
            `CHK("serial_dout", (rcnt >= 9 && rcnt <= 20) ? exp_code[0] : 1'b0, serial_dout)
            `CHK("conversion_strobe", rcnt == 8, conversion_strobe)
            `CHK("output_enables", 2'h3, {serial_dout_oe, conversion_strobe_oe})
         end
      end
      if (chip_select_n) rcnt <= 0;
      if (result_valid) begin
         nres = nres + 1;
         `CHK("result_code", exp_code, result_code)
      end
   end
   initial begin
      reset_n = 1'b0;
      hw_shutdown_n = 1'b1;
      comparator_bit = 1'b0;
      sclk_q = 1'b0;
      repeat (5) @(negedge core_clk);
      reset_n = 1'b1;
      repeat (6) @(negedge core_clk);
      `CHK("power_sel", 2'h3, power_sel)
      for (i = 0; i < 12; i = i + 1) begin
         seed = xs(seed);
         f = (i < 4) ? 3 - i : seed[1:0];
         nres = 0;
         // after deep sleep this frame wakes the part and still gives one checked conversion
         host.frame({1'b1, seed[8:4], f});
         repeat (10) @(negedge core_clk);
         `CHK("conversions", 1, nres)
         `CHK("power_sel", f, power_sel)
         `CHK("output_enables", 2'h0, {serial_dout_oe, conversion_strobe_oe})
         $display("frame %0d field %0d done", i, f);
      end
      nres = 0;
      fork
         host.frame(8'h8F);
         begin
            wait (rcnt == 14);
            hw_shutdown_n = 1'b0;
         end
      join
      host.frame(8'h8F);
      @(negedge core_clk);
      hw_shutdown_n = 1'b1;
      repeat (12) @(negedge core_clk);
      host.frame(8'h8F);
      repeat (10) @(negedge core_clk);
      `CHK("conversions", 1, nres)
      $display("shutdown test done");
      wrap_up;
   end
endmodule // apms_sequencer_tb
